// *** dv/cfs_global_regs_props.sv ***
`timescale 1ns/1ps
module cfs_global_regs_props (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Register port
  input logic [15:0] reg_addr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  // Sources
  input logic fault_valid,
  input logic [2:0] ring_job_active,
  input logic engine_job_active,
  input logic rng_request_active,
  input logic [2:0] ring_timer_counting,
  input logic irq_pending_unmasked,
  input logic secmem_idle,
  input logic checker_idle_reporting,
  input logic checker_runtime_mode,
  input logic [3:0] runtime_block_enable,
  input logic checker_hash_active,
  // Mirrors
  input logic unit_busy,
  input logic unit_idle,
  input logic fault_held
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_status_rd;
    reg_rd && reg_addr[11:0] == 12'hFD4;
  endsequence
  sequence s_capture;
    fault_valid && !fault_held;
  endsequence
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without a strobe");
  bad_alias_a: assert property (reg_rd && reg_addr[15:12] == 4'h4 |=>
    reg_rdata == 32'h0) else $error("unmapped alias answered");
  status_rsvd_a: assert property (s_status_rd |=>
    reg_rdata[31:11] == 21'h0 && reg_rdata[7:3] == 5'h0)
    else $error("status reserved bits set");
  busy_track_a: assert property (unit_busy ==
    $past(|ring_job_active || engine_job_active || rng_request_active))
    else $error("busy does not follow job sources");
  idle_terms_a: assert property (|ring_timer_counting ||
    irq_pending_unmasked || !secmem_idle |=> !unit_idle)
    else $error("idle despite pending work");
  idle_runtime_a: assert property (checker_idle_reporting &&
    checker_runtime_mode && |runtime_block_enable |=> !unit_idle)
    else $error("idle during checker run time");
  idle_hash_a: assert property (!checker_idle_reporting &&
    checker_hash_active |=> !unit_idle) else $error("idle while hashing");
  fault_cap_a: assert property (s_capture |-> ##2 fault_held)
    else $error("fault not captured");
  // Held flag lags the clear by a cycle, so skip two cycles after a read
  fault_hold_a: assert property (fault_held && !reg_rd &&
    !$past(reg_rd) |=> fault_held) else $error("fault dropped unread");
endmodule
bind cfs_global_regs cfs_global_regs_props props_i (.*);

// *** dv/cfs_global_regs_tb.sv ***
`timescale 1ns/1ps
module cfs_global_regs_tb;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic fault_valid = 1'b0, entropy_idle = 1'b0;
  logic [15:0] reg_addr = 16'h0, fault_id_in = 16'hABCD;
  logic [31:0] reg_wdata = 32'h0, fault_addr_in = 32'h1234_5678;
  logic [1:0] fault_err_code = 2'h2, security_mode_state = 2'h0;
  logic [2:0] fault_extra_flags = 3'h5;
  logic [4:0] bv = 5'h0;
  logic [11:0] iv = 12'h010;
  logic [20:0] fv = 21'h0;
  wire [31:0] reg_rdata;
  wire [2:0] ring_job_active, ring_timer_counting, fault_job_origin;
  wire [3:0] runtime_block_enable, fault_initiator_id;
  wire [9:0] fault_size;
  wire engine_job_active, rng_request_active, irq_pending_unmasked;
  wire secmem_idle, checker_idle_reporting, checker_runtime_mode;
  wire checker_hash_active, fault_key_read, fault_modifier_read;
  wire fault_data_kind, fault_rw_kind, unit_busy, unit_idle, fault_held;
  int num_errors = 0, n_tests = 0;
  // Idle input pattern with the expected idle bit on top
  logic [12:0] itab [7] = '{13'h1010, 13'h0012, 13'h0018, 13'h0000,
    13'h00F0, 13'h1070, 13'h0810};
  logic [3:0] spc [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8};
  assign {rng_request_active, engine_job_active, ring_job_active} = bv;
  assign {checker_hash_active, runtime_block_enable, checker_runtime_mode,
    checker_idle_reporting, secmem_idle, irq_pending_unmasked,
    ring_timer_counting} = iv;
  assign {fault_key_read, fault_modifier_read, fault_data_kind,
    fault_rw_kind, fault_size, fault_job_origin, fault_initiator_id} = fv;
  cfs_global_regs dut (.*);
  always #12.5 clk = ~clk;
  task chk(input [31:0] g, input [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task rd(input [15:0] a, input [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task wr(input [15:0] a, input [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task flt(input [20:0] v);
    @(posedge clk);
    fv <= v;
    fault_valid <= 1'b1;
    @(posedge clk);
    fault_valid <= 1'b0;
    settle;
  endtask
  task tally_and_finish;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (spc[i]) rd({spc[i], 12'hFD4}, 32'h2);
    rd(16'h4FD4, 32'h0);
    rd(16'h0FD6, 32'h0);
    wr(16'h0FD8, 32'hFFFF_FFFF);
    rd(16'h3FD8, 32'h03FF_F01F);
    rd(16'h6FDC, 32'h0002_0300);
    rd(16'h8FE0, 32'h0F05_0100);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      security_mode_state <= m[1:0];
      entropy_idle <= m[0];
      settle;
      rd(16'h2FD4, {22'h0, m[1:0], 5'h0, m[0], 2'h2});
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      bv <= 5'h4 << i;
      settle;
      chk(unit_busy, 32'h1);
      chk(unit_idle, 32'h0);
      rd(16'h1FD4, 32'h0000_0305);
    end
    @(posedge clk);
    bv <= 5'h0;
    foreach (itab[i]) begin
      @(posedge clk);
      iv <= itab[i][11:0];
      settle;
      chk(unit_idle, {31'h0, itab[i][12]});
    end
    flt(21'h17_52C8);
    chk(fault_held, 32'h1);
    flt(21'h08_0015);
    rd(16'h2FCC, 32'h9605_C8A5);
    rd(16'h0FC0, 32'h1234_5678);
    chk(fault_held, 32'h1);
    rd(16'h8FC8, 32'h0000_ABCD);
    settle;
    chk(fault_held, 32'h0);
    rd(16'h0FCC, 32'h0);
    flt(21'h08_0015);
    rd(16'h1FCC, 32'h9500_1500);
    tally_and_finish;
  end
  initial begin
    #50000;
    num_errors++;
    tally_and_finish;
  end
endmodule

// *** logic/cfs_fault_capture.v ***
`timescale 1ns/1ps
`include "cfs_regs.vh"
module cfs_fault_capture (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Fault report from DMA
  input wire fault_valid,
  input wire [31:0] fault_addr_in,
  input wire [15:0] fault_id_in,
  input wire [31:0] fault_detail_in,
  // Read pulses for the three fault words
  input wire rd_addr,
  input wire rd_id,
  input wire rd_detail,
  // Held values
  output reg [31:0] fault_addr,
  output reg [15:0] fault_id,
  output reg [31:0] fault_detail,
  output reg held
);
  reg [2:0] seen;
  wire [2:0] next_seen;
  assign next_seen = seen | {rd_detail, rd_id, rd_addr};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 1'b0;
      seen <= 3'h0;
      fault_addr <= 32'h0;
      fault_id <= 16'h0;
      fault_detail <= 32'h0;
    end else if (!held) begin
      if (fault_valid) begin
        held <= 1'b1;
        fault_addr <= fault_addr_in;
        fault_id <= fault_id_in;
        fault_detail <= fault_detail_in;
      end
    end else if (next_seen == 3'h7) begin
      // All three read: clear together, later faults may land again
      held <= 1'b0;
      seen <= 3'h0;
      fault_addr <= 32'h0;
      fault_id <= 16'h0;
      fault_detail <= 32'h0;
    end else begin
      seen <= next_seen;
    end
  end
endmodule

// *** logic/cfs_global_regs.v ***
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "cfs_regs.vh"
module cfs_global_regs #(
  parameter PLATFORM_BIG_ENDIAN = 1'b0,
  parameter SECMEM_PRESENT = 1'b1,
  parameter [9:0] MAX_PAGE_INDEX = 10'h3FF,
  parameter [3:0] TOP_PARTITION_INDEX = 4'hF,
  parameter [9:0] TOP_PAGE_INDEX = 10'h01F,
  parameter [2:0] PAGE_SIZE_CODE = 3'h2,
  parameter [7:0] SECMEM_MAJOR = 8'h03,
  parameter [7:0] SECMEM_MINOR = 8'h00,
  parameter [3:0] CHECKER_BLOCKS = 4'hF,
  parameter CHECKER_SHA256 = 1'b1,
  parameter CHECKER_SHA512 = 1'b1,
  // Version values below are arbitrary
  parameter [7:0] CHECKER_MAJOR = 8'h01,
  parameter [7:0] CHECKER_MINOR = 8'h00,
  parameter [7:0] CLUSTER_ERA = 8'h01,
  parameter [7:0] CLUSTER_MAJOR = 8'h01,
  parameter [7:0] CLUSTER_MINOR = 8'h00
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Fault capture from DMA
  input wire fault_valid,
  input wire [31:0] fault_addr_in,
  input wire [15:0] fault_id_in,
  input wire fault_key_read,
  input wire fault_modifier_read,
  input wire [9:0] fault_size,
  input wire fault_data_kind,
  input wire [2:0] fault_job_origin,
  input wire [3:0] fault_initiator_id,
  input wire fault_rw_kind,
  input wire [1:0] fault_err_code,
  input wire [2:0] fault_extra_flags,
  // Unit status sources
  input wire [1:0] security_mode_state,
  input wire entropy_idle,
  input wire [2:0] ring_job_active,
  input wire engine_job_active,
  input wire rng_request_active,
  input wire [2:0] ring_timer_counting,
  input wire irq_pending_unmasked,
  input wire secmem_idle,
  input wire checker_idle_reporting,
  input wire checker_runtime_mode,
  input wire [3:0] runtime_block_enable,
  input wire checker_hash_active,
  // Status mirrors
  output reg unit_busy,
  output reg unit_idle,
  output reg fault_held
);
  wire [31:0] fault_addr;
  wire [15:0] fault_id;
  wire [31:0] fault_detail;
  wire held;
  wire [31:0] detail_in;
  wire [11:0] off;
  wire alias_ok;
  wire rd_ok;
  wire next_busy;
  wire checker_blocks_idle;
  wire next_idle;
  wire [31:0] status_word;
  reg [31:0] next_rdata;

  // Offset within one 4 KB space; top nibble picks the alias space
  function alias_hit;
    input [15:0] a;
    reg [15:0] map;
    begin
      map = `CFS_ALIAS_MAP;
      alias_hit = map[a[15:12]] & (a[1:0] == 2'h0);
    end
  endfunction

  assign off = reg_addr[11:0] & `CFS_OFF_MASK;
  assign alias_ok = alias_hit(reg_addr);
  assign rd_ok = reg_rd & alias_ok;

  assign detail_in = {fault_err_code, 1'b0, fault_extra_flags,
    fault_key_read,
    fault_modifier_read,
    5'h00, fault_size[9:7],
    fault_data_kind,
    fault_job_origin,
    fault_initiator_id,
    fault_rw_kind,
    fault_size[6:0]};

  cfs_fault_capture u_fault (
    .clk(clk),
    .rst_n(rst_n),
    .fault_valid(fault_valid),
    .fault_addr_in(fault_addr_in),
    .fault_id_in(fault_id_in),
    .fault_detail_in(detail_in),
    .rd_addr(rd_ok & (off == `CFS_OFF_FAULT_ADDR)),
    .rd_id(rd_ok & (off == `CFS_OFF_FAULT_ID)),
    .rd_detail(rd_ok & (off == `CFS_OFF_FAULT_DETAIL)),
    .fault_addr(fault_addr),
    .fault_id(fault_id),
    .fault_detail(fault_detail),
    .held(held)
  );

  assign next_busy = (|ring_job_active) | engine_job_active |
    rng_request_active;
  // Idle-reporting set blocks idle in run-time mode only while a run-time block is enabled
  assign checker_blocks_idle = checker_idle_reporting ?
    (checker_runtime_mode & (|runtime_block_enable)) :
    checker_hash_active;
  assign next_idle = ~next_busy & ~(|ring_timer_counting) &
    ~irq_pending_unmasked & secmem_idle & ~checker_blocks_idle;

  assign status_word = {21'h0, PLATFORM_BIG_ENDIAN[0],
    security_mode_state,
    5'h0, entropy_idle,
    unit_idle, unit_busy};

  // Reads return registered status so the word matches the mirror pins
  always @* begin
    next_rdata = 32'h0;
    if (rd_ok) begin
      case (off)
        `CFS_OFF_FAULT_ADDR: next_rdata = fault_addr;
        `CFS_OFF_FAULT_ID: next_rdata = {16'h0, fault_id};
        `CFS_OFF_FAULT_DETAIL: next_rdata = fault_detail;
        `CFS_OFF_UNIT_STATUS: next_rdata = status_word;
        `CFS_OFF_SECMEM_GEOM: next_rdata = {6'h0,
          MAX_PAGE_INDEX,
          TOP_PARTITION_INDEX,
          2'h0, TOP_PAGE_INDEX};
        `CFS_OFF_SECMEM_VER: next_rdata = {13'h0,
          PAGE_SIZE_CODE,
          (SECMEM_PRESENT ? SECMEM_MAJOR : 8'h00),
          SECMEM_MINOR};
        `CFS_OFF_CHECKER_VER: next_rdata = {4'h0,
          CHECKER_BLOCKS, 5'h0,
          CHECKER_SHA512[0], 1'b0, CHECKER_SHA256[0],
          CHECKER_MAJOR, CHECKER_MINOR};
        `CFS_OFF_CLUSTER_VER: next_rdata = {CLUSTER_ERA, 8'h00,
          CLUSTER_MAJOR, CLUSTER_MINOR};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // Writes have no target: reg_wr and reg_wdata are deliberately unused
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
      unit_busy <= 1'b0;
      unit_idle <= 1'b1;
      fault_held <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      unit_busy <= next_busy;
      unit_idle <= next_idle;
      fault_held <= held;
    end
  end
endmodule

// *** logic/cfs_regs.vh ***
`ifndef CFS_REGS_VH
`define CFS_REGS_VH
`define CFS_ADDR_W 16
`define CFS_OFF_MASK 12'hFFF
`define CFS_OFF_FAULT_ADDR 12'hFC0
`define CFS_OFF_FAULT_ID 12'hFC8
`define CFS_OFF_FAULT_DETAIL 12'hFCC
`define CFS_OFF_UNIT_STATUS 12'hFD4
`define CFS_OFF_SECMEM_GEOM 12'hFD8
`define CFS_OFF_SECMEM_VER 12'hFDC
`define CFS_OFF_CHECKER_VER 12'hFE0
`define CFS_OFF_CLUSTER_VER 12'hFE4
`define CFS_ALIAS_MAP 16'h014F
`define CFS_FD_KEY 25
`define CFS_FD_MOD 24
`define CFS_FD_SZHI_LSB 16
`define CFS_FD_KIND 15
`define CFS_FD_ORIGIN_LSB 12
`define CFS_FD_INIT_LSB 8
`define CFS_FD_RW 7
`define CFS_ST_ENDIAN 10
`define CFS_ST_MODE_LSB 8
`define CFS_ST_ENTROPY 2
`define CFS_ST_IDLE 1
`define CFS_ST_BUSY 0
`define CFS_GEOM_MAX_LSB 16
`define CFS_GEOM_PRT_LSB 12
`define CFS_VER_PSIZ_LSB 16
`define CFS_VER_MAJ_LSB 8
`define CFS_CHK_BLK_LSB 24
`define CFS_CHK_S512 18
`define CFS_CHK_S256 16
`define CFS_CHK_MAJ_LSB 8
`define CFS_CLU_ERA_LSB 24
`define CFS_CLU_MAJ_LSB 8
`define CFS_RST_STATUS 32'h0000_0002
`endif
